/* File: design/lsirq_pkg.sv */
// package: register offsets, reset values and carrier types of the light sensor irq/status bank
// assumes: shared by the register bank and its two helper modules
package lsirq_pkg;

    localparam logic [7:0] OFS_INT_CFG = 8'h0b;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_PART_ID = 8'h11;

    localparam logic [9:0] RSV_FIELD_RST = 10'h200;
    localparam logic COMPARE_SRC_RST = 1'h0;
    localparam logic IRQ_DIR_RST = 1'h1;
    localparam logic BURST_RST = 1'h1;
    localparam logic [7:0] PTR_RST = 8'h00;

    // bit positions inside the interrupt and bus config word
    localparam int CFG_RSV_LSB = 6;
    localparam int CFG_SRC_BIT = 5;
    localparam int CFG_DIR_BIT = 4;
    localparam int CFG_EOC_LSB = 2;
    localparam int CFG_BURST_BIT = 0;

    // identification fields, values arbitrary
    localparam logic [1:0] PART_ID_LOW_DFLT = 2'h1;
    localparam logic [11:0] PART_ID_HIGH_DFLT = 12'h5a3;

    localparam int RES_W_DFLT = 20;
    localparam int FAULT_CNT_W = 4;
    localparam int EOC_CNT_W = 2;

    typedef enum logic [1:0] {
        EOC_ALERT = 2'h0,
        EOC_EVERY1 = 2'h1,
        EOC_EVERY2 = 2'h2,
        EOC_EVERY4 = 2'h3
    } lsirq_eoc_mode_t;

    typedef struct packed {
        logic [9:0] rsv_field;
        logic compare_source_select;
        logic irq_pin_dir;
        lsirq_eoc_mode_t eoc_mode;
        logic burst_en;
    } lsirq_cfg_t;

    typedef struct packed {
        logic range_overflow_status;
        logic conv_ready_status;
        logic above_limit_status;
        logic below_limit_status_short;
    } lsirq_status_t;

    localparam lsirq_cfg_t CFG_RST = '{
        rsv_field: RSV_FIELD_RST,
        compare_source_select: COMPARE_SRC_RST,
        irq_pin_dir: IRQ_DIR_RST,
        eoc_mode: EOC_ALERT,
        burst_en: BURST_RST
    };

endpackage : lsirq_pkg

/* File: design/lsirq_fault_run.sv */
// consecutive-fault run counter for one threshold direction
// assumes: sample_i is a one-cycle pulse per finished conversion, same clock
`timescale 1ns/100ps
`default_nettype none
module lsirq_fault_run (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sample_i,
    input wire logic hit_i,
    input wire logic [1:0] fault_count_i,
    output logic qualify_o
);
    logic [lsirq_pkg::FAULT_CNT_W-1:0] cnt_q, cnt_d, need;
    logic qualify_q, qualify_d;

    always_comb
    begin
        // 0,1,2,3 -> 1,2,4,8 results in a row
        need = lsirq_pkg::FAULT_CNT_W'(1) << fault_count_i;
        cnt_d = cnt_q;
        qualify_d = 1'b0;
        if (sample_i)
        begin
            if (!hit_i)
            begin
                cnt_d = '0;
            end
            else if (cnt_q + lsirq_pkg::FAULT_CNT_W'(1) >= need)
            begin
                // saturate so a long run keeps qualifying each result
                cnt_d = need;
                qualify_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + lsirq_pkg::FAULT_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= '0;
            qualify_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            qualify_q <= qualify_d;
        end
    end

    assign qualify_o = qualify_q;

endmodule : lsirq_fault_run
`default_nettype wire

/* File: design/lsirq_eoc_div.sv */
// end-of-conversion divider: fires after every 1, 2 or 4 conversions
// assumes: conv_done_i one-cycle pulse, same clock
`timescale 1ns/100ps
`default_nettype none
module lsirq_eoc_div (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic conv_done_i,
    input wire lsirq_pkg::lsirq_eoc_mode_t mode_i,
    output logic fire_o
);
    logic [lsirq_pkg::EOC_CNT_W-1:0] cnt_q, cnt_d, last;
    logic fire_q, fire_d;

    always_comb
    begin
        unique case (mode_i)
            lsirq_pkg::EOC_EVERY2: last = 2'h1;
            lsirq_pkg::EOC_EVERY4: last = 2'h3;
            lsirq_pkg::EOC_EVERY1,
            lsirq_pkg::EOC_ALERT: last = 2'h0;
        endcase
        cnt_d = cnt_q;
        fire_d = 1'b0;
        if (conv_done_i)
        begin
            if (cnt_q >= last)
            begin
                cnt_d = '0;
                fire_d = (mode_i != lsirq_pkg::EOC_ALERT);
            end
            else
            begin
                cnt_d = cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= '0;
            fire_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            fire_q <= fire_d;
        end
    end

    assign fire_o = fire_q;

endmodule : lsirq_eoc_div
`default_nettype wire

/* File: design/lsirq_regs.sv */
// interrupt config, event status and part id registers of a dual-channel light sensor
// assumes: the serial engine presents pointer loads, reads and writes as one-cycle strobes
// Operation
// - reserved upper config field resets to 200h and stores what host writes
// - compare source: visible channel when bit is 0, infrared channel when 1
// - interrupt pin is input when direction bit 0, driven output when 1
// - eoc field: 0 alert, 1 every conversion, 2 every two, 3 every four
// - with burst set, read pointer advances by one after every read
// - overload status set when a conversion overflows
// - conversion-complete set at conversion end, held until cleared, resets 0
// - conversion-complete cleared by status read or non-zero status write
// - high flag set after enough consecutive results above high threshold
// - low flag set after enough consecutive results below low threshold
// - fault count 0,1,2,3 means 1,2,4,8 consecutive results
// - interrupt pin active low for polarity 0, active high for 1
`timescale 1ns/100ps
`default_nettype none
module lsirq_regs #(
    parameter int RES_W = lsirq_pkg::RES_W_DFLT,
    parameter logic [1:0] PART_ID_LOW = lsirq_pkg::PART_ID_LOW_DFLT,
    parameter logic [11:0] PART_ID_HIGH = lsirq_pkg::PART_ID_HIGH_DFLT
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ptr_load_i,
    input wire logic [7:0] ptr_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic [7:0] reg_ptr_o,
    input wire logic conv_done_i,
    input wire logic conv_overflow_i,
    input wire logic [RES_W-1:0] visible_channel_i,
    input wire logic [RES_W-1:0] infrared_channel_i,
    input wire logic [RES_W-1:0] thresh_high_i,
    input wire logic [RES_W-1:0] thresh_low_i,
    input wire logic [1:0] fault_count_i,
    input wire logic irq_pin_polarity_i,
    input wire logic irq_pin_i,
    output logic irq_pin_o,
    output logic irq_pin_oe_o,
    output logic ext_trigger_o
);
    logic rst_s1_q, rst_n;
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    lsirq_pkg::lsirq_cfg_t cfg_q, cfg_d;
    lsirq_pkg::lsirq_status_t stat_q, stat_d;
    logic [1:0] id_rsv_q, id_rsv_d;
    logic [7:0] ptr_q, ptr_d;
    logic [15:0] rdata_q, rdata_d, rd_word;
    logic irq_act_q, irq_act_d;
    logic trig_q, trig_d;
    logic [RES_W-1:0] cmp_val;
    logic hi_hit, lo_hit, hi_qual, lo_qual, eoc_fire, stat_acc;

    // reset released through two flops
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // external pin crosses in through two flops; third is for edge detect only
    // reset to the pulled-up idle level so no false edge follows reset
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_s3_q <= 1'b1;
        end
        else
        begin
            pin_s1_q <= irq_pin_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign cmp_val = cfg_q.compare_source_select ? infrared_channel_i : visible_channel_i;
    assign hi_hit = cmp_val > thresh_high_i;
    assign lo_hit = cmp_val < thresh_low_i;

    lsirq_fault_run u_run_high (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .sample_i(conv_done_i),
        .hit_i(hi_hit),
        .fault_count_i(fault_count_i),
        .qualify_o(hi_qual)
    );

    lsirq_fault_run u_run_low (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .sample_i(conv_done_i),
        .hit_i(lo_hit),
        .fault_count_i(fault_count_i),
        .qualify_o(lo_qual)
    );

    lsirq_eoc_div u_eoc (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .conv_done_i(conv_done_i),
        .mode_i(cfg_q.eoc_mode),
        .fire_o(eoc_fire)
    );

    // read view; reserved bits of status and config bit 1 read zero
    always_comb
    begin
        unique case (ptr_q)
            lsirq_pkg::OFS_INT_CFG: rd_word = {cfg_q.rsv_field, cfg_q.compare_source_select,
                cfg_q.irq_pin_dir, cfg_q.eoc_mode, 1'b0, cfg_q.burst_en};
            lsirq_pkg::OFS_STATUS: rd_word = {12'h000, stat_q};
            lsirq_pkg::OFS_PART_ID: rd_word = {id_rsv_q, PART_ID_LOW, PART_ID_HIGH};
            default: rd_word = 16'h0000;
        endcase
    end

    assign stat_acc = (reg_rd_i && ptr_q == lsirq_pkg::OFS_STATUS)
        || (reg_wr_i && ptr_q == lsirq_pkg::OFS_STATUS && reg_wdata_i != 16'h0000);

    always_comb
    begin
        cfg_d = cfg_q;
        id_rsv_d = id_rsv_q;
        ptr_d = ptr_q;
        rdata_d = rdata_q;
        stat_d = stat_q;
        irq_act_d = irq_act_q;
        if (ptr_load_i)
        begin
            ptr_d = ptr_addr_i;
        end
        else if (reg_rd_i)
        begin
            rdata_d = rd_word;
            if (cfg_q.burst_en)
            begin
                ptr_d = ptr_q + 8'h01;
            end
        end
        else if (reg_wr_i && ptr_q == lsirq_pkg::OFS_INT_CFG)
        begin
            // reserved field stored as written; bit 1 ignored
            cfg_d.rsv_field = reg_wdata_i[15:lsirq_pkg::CFG_RSV_LSB];
            cfg_d.compare_source_select = reg_wdata_i[lsirq_pkg::CFG_SRC_BIT];
            cfg_d.irq_pin_dir = reg_wdata_i[lsirq_pkg::CFG_DIR_BIT];
            cfg_d.eoc_mode = lsirq_pkg::lsirq_eoc_mode_t'(reg_wdata_i[lsirq_pkg::CFG_EOC_LSB +: 2]);
            cfg_d.burst_en = reg_wdata_i[lsirq_pkg::CFG_BURST_BIT];
        end
        else if (reg_wr_i && ptr_q == lsirq_pkg::OFS_PART_ID)
        begin
            id_rsv_d = reg_wdata_i[15:14];
        end
        // clear first, then events, so a set in the same cycle wins
        if (stat_acc)
        begin
            stat_d.conv_ready_status = 1'b0;
            // threshold flags latch until the host reads the status word or writes it non-zero
            stat_d.above_limit_status = 1'b0;
            stat_d.below_limit_status_short = 1'b0;
            irq_act_d = 1'b0;
        end
        if (conv_done_i)
        begin
            stat_d.conv_ready_status = 1'b1;
            stat_d.range_overflow_status = conv_overflow_i;
        end
        if (hi_qual)
        begin
            stat_d.above_limit_status = 1'b1;
        end
        if (lo_qual)
        begin
            stat_d.below_limit_status_short = 1'b1;
        end
        if (cfg_q.eoc_mode == lsirq_pkg::EOC_ALERT ? (hi_qual || lo_qual) : eoc_fire)
        begin
            irq_act_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_q <= lsirq_pkg::CFG_RST;
            stat_q <= '0;
            id_rsv_q <= 2'h0;
            ptr_q <= lsirq_pkg::PTR_RST;
            rdata_q <= 16'h0000;
            irq_act_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            stat_q <= stat_d;
            id_rsv_q <= id_rsv_d;
            ptr_q <= ptr_d;
            rdata_q <= rdata_d;
            irq_act_q <= irq_act_d;
        end
    end

    // pin as input: active edge becomes a trigger pulse for the conversion engine
    always_comb
    begin
        trig_d = !cfg_q.irq_pin_dir
            && ((pin_s2_q == irq_pin_polarity_i) && (pin_s3_q != irq_pin_polarity_i));
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_q <= 1'b0;
        end
        else
        begin
            trig_q <= trig_d;
        end
    end

    assign irq_pin_oe_o = cfg_q.irq_pin_dir;
    assign irq_pin_o = irq_pin_polarity_i ? irq_act_q : !irq_act_q;
    assign ext_trigger_o = trig_q;
    assign reg_rdata_o = rdata_q;
    assign reg_ptr_o = ptr_q;

    AST_READY_SET: assert property (@(posedge clk_i) disable iff (!rst_n)
        conv_done_i |=> stat_q.conv_ready_status)
        else $error("ready flag not set after conversion end");
    AST_READY_CLR: assert property (@(posedge clk_i) disable iff (!rst_n)
        (stat_acc && !conv_done_i) |=> !stat_q.conv_ready_status)
        else $error("ready flag not cleared by status access");
    AST_OVERLOAD: assert property (@(posedge clk_i) disable iff (!rst_n)
        conv_done_i |=> stat_q.range_overflow_status == $past(conv_overflow_i))
        else $error("range_overflow_status does not follow conversion");
    AST_BURST: assert property (@(posedge clk_i) disable iff (!rst_n)
        (reg_rd_i && !ptr_load_i && cfg_q.burst_en) |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("burst pointer did not advance");
    AST_NO_BURST: assert property (@(posedge clk_i) disable iff (!rst_n)
        (reg_rd_i && !ptr_load_i && !cfg_q.burst_en) |=> $stable(ptr_q))
        else $error("pointer moved with burst off");
    AST_PIN_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n)
        irq_pin_o == (irq_act_q ~^ irq_pin_polarity_i))
        else $error("interrupt pin level wrong for polarity");
    AST_HIGH_RUN: assert property (@(posedge clk_i) disable iff (!rst_n)
        (fault_count_i == 2'h0 && conv_done_i && hi_hit) |-> ##2 stat_q.above_limit_status)
        else $error("high flag missing after single qualifying result");
    AST_LOW_RUN: assert property (@(posedge clk_i) disable iff (!rst_n)
        (fault_count_i == 2'h0 && conv_done_i && lo_hit) |-> ##2 stat_q.below_limit_status_short)
        else $error("low flag missing after single qualifying result");
    AST_LOW_BREAK: assert property (@(posedge clk_i) disable iff (!rst_n)
        (conv_done_i && !lo_hit) |=> !lo_qual)
        else $error("low flag qualified across a broken run");
    AST_HIGH_SET: assert property (@(posedge clk_i) disable iff (!rst_n)
        hi_qual |=> stat_q.above_limit_status)
        else $error("high flag not set after qualifying run");
    AST_LOW_SET: assert property (@(posedge clk_i) disable iff (!rst_n)
        lo_qual |=> stat_q.below_limit_status_short)
        else $error("low flag not set after qualifying run");
    AST_EOC_EVERY1: assert property (@(posedge clk_i) disable iff (!rst_n)
        (conv_done_i && cfg_q.eoc_mode == lsirq_pkg::EOC_EVERY1 && !stat_acc) ##1
        (!stat_acc && $stable(cfg_q)) |=> irq_act_q)
        else $error("interrupt not raised after conversion");
    AST_EOC_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n)
        (conv_done_i && cfg_q.eoc_mode == lsirq_pkg::EOC_ALERT) |=> !eoc_fire)
        else $error("conversion interrupt fired in alert mode");
    AST_TRIG_OUT_MODE: assert property (@(posedge clk_i) disable iff (!rst_n)
        cfg_q.irq_pin_dir |=> !ext_trigger_o)
        else $error("trigger taken while pin is an output");
    AST_TRIG_ONE: assert property (@(posedge clk_i) disable iff (!rst_n)
        ext_trigger_o |=> !ext_trigger_o)
        else $error("trigger pulse longer than one cycle");
    AST_CFG_RESET: assert property (@(posedge clk_i) $rose(rst_n) |->
        cfg_q == lsirq_pkg::CFG_RST)
        else $error("config word not at reset value");

    COV_BURST_READ: cover property (@(posedge clk_i) disable iff (!rst_n)
        reg_rd_i && cfg_q.burst_en ##1 reg_rd_i);
    COV_HIGH_FLAG: cover property (@(posedge clk_i) disable iff (!rst_n)
        $rose(stat_q.above_limit_status));
    COV_SET_CLEAR: cover property (@(posedge clk_i) disable iff (!rst_n)
        conv_done_i && stat_acc);
    COV_EXT_TRIG: cover property (@(posedge clk_i) disable iff (!rst_n) ext_trigger_o);
    COV_EOC_EVERY4: cover property (@(posedge clk_i) disable iff (!rst_n)
        cfg_q.eoc_mode == lsirq_pkg::EOC_EVERY4 && eoc_fire);

endmodule : lsirq_regs
`default_nettype wire

/* File: testbench/lsirq_host_model.sv */
// host model: pointer loads, reads and writes as the serial engine presents them
// assumes: shares clk_i with the bank; strobes change on falling edges only
`timescale 1ns/100ps
`default_nettype none
module lsirq_host_model (
    input wire logic clk_i,
    output logic ptr_load_o,
    output logic [7:0] ptr_addr_o,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [15:0] reg_wdata_o,
    input wire logic [15:0] reg_rdata_i
);
    initial
    begin
        ptr_load_o = 1'b0;
        ptr_addr_o = 8'hff;
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_wdata_o = 16'hffff;
    end

    // released address and data lines show the inverse, never a stale copy
    task automatic load_ptr(input logic [7:0] a);
        @(negedge clk_i);
        ptr_load_o = 1'b1;
        ptr_addr_o = a;
        @(negedge clk_i);
        ptr_load_o = 1'b0;
        ptr_addr_o = ~a;
    endtask : load_ptr

    // ld low reads at the current pointer, as a burst continuation does
    task automatic rd(input logic [7:0] a, input logic ld, output logic [15:0] d);
        if (ld)
            load_ptr(a);
        else
            @(negedge clk_i);
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        d = reg_rdata_i;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        logic [15:0] w;
        w = v;
        if (a == lsirq_pkg::OFS_INT_CFG)
            w[1] = 1'b0;
        if (a == lsirq_pkg::OFS_STATUS)
            w[15:4] = 12'h000;
        if (a == lsirq_pkg::OFS_PART_ID)
            w[15:14] = 2'h0;
        load_ptr(a);
        reg_wr_o = 1'b1;
        reg_wdata_o = w;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~w;
    endtask : wr
endmodule : lsirq_host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// testbench: register accesses, conversions and pin checks on the irq/status bank
// assumes: host model owns the register strobes; the pin has a pull-up
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int RW = 8;
    logic clk_i;
    logic resetn_i;
    logic ptr_load, reg_rd, reg_wr, conv_done, conv_ovf, pol, pin_ext, irq_o, irq_oe, trig;
    logic [7:0] ptr_addr, reg_ptr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [RW-1:0] vis, ir, th_hi, th_lo;
    logic [1:0] fault_count;
    wire logic pin_lvl;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;

    // external level pin_ext wins whenever the bank is not driving
    assign pin_lvl = irq_oe ? irq_o : pin_ext;

    lsirq_host_model u_lsirq_host_model (.clk_i(clk_i), .ptr_load_o(ptr_load),
        .ptr_addr_o(ptr_addr), .reg_rd_o(reg_rd), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

    lsirq_regs #(.RES_W(RW)) u_lsirq_regs (.clk_i(clk_i), .resetn_i(resetn_i),
        .ptr_load_i(ptr_load), .ptr_addr_i(ptr_addr), .reg_rd_i(reg_rd),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .reg_ptr_o(reg_ptr), .conv_done_i(conv_done), .conv_overflow_i(conv_ovf),
        .visible_channel_i(vis), .infrared_channel_i(ir), .thresh_high_i(th_hi),
        .thresh_low_i(th_lo), .fault_count_i(fault_count), .irq_pin_polarity_i(pol),
        .irq_pin_i(pin_lvl), .irq_pin_o(irq_o), .irq_pin_oe_o(irq_oe),
        .ext_trigger_o(trig));

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_lsirq_host_model.rd(a, 1'b1, d);
        chk(d, e);
    endtask : rdc

    // one result pair; waits past the threshold and irq latency
    task automatic conv(input logic [RW-1:0] v, input logic [RW-1:0] r, input logic o);
        @(negedge clk_i);
        conv_done = 1'b1;
        vis = v;
        ir = r;
        conv_ovf = o;
        @(negedge clk_i);
        conv_done = 1'b0;
        vis = ~v;
        ir = ~r;
        conv_ovf = ~o;
        repeat (3) @(negedge clk_i);
    endtask : conv

    task automatic cnt_trig;
        n = 0;
        repeat (8)
        begin
            @(negedge clk_i);
            n += int'(trig);
        end
    endtask : cnt_trig

    initial
    begin
        logic [15:0] d;
        resetn_i = 1'b0;
        conv_done = 1'b0;
        conv_ovf = 1'b0;
        vis = 8'h00;
        ir = 8'h00;
        th_hi = 8'hf0;
        th_lo = 8'h10;
        fault_count = 2'h0;
        pol = 1'b0;
        pin_ext = 1'b1;
        repeat (5) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        rdc(8'h0b, 16'h8011);
        rdc(8'h0c, 16'h0000);
        rdc(8'h11, 16'h15a3);
        rdc(8'h0d, 16'h0000);
        u_lsirq_host_model.rd(8'h0b, 1'b1, d);
        u_lsirq_host_model.rd(8'h00, 1'b0, d);
        u_lsirq_host_model.rd(8'h00, 1'b0, d);
        chk({8'h00, reg_ptr}, 16'h000e);
        u_lsirq_host_model.wr(8'h0b, 16'h2020);
        rdc(8'h0b, 16'h2020);
        chk({8'h00, reg_ptr}, 16'h000b);
        chk({15'h0, irq_oe}, 16'h0000);
        pin_ext = 1'b0;
        cnt_trig();
        chk(16'(n), 16'h0001);
        pin_ext = 1'b1;
        cnt_trig();
        chk(16'(n), 16'h0000);
        conv(8'h40, 8'h40, 1'b1);
        rdc(8'h0c, 16'h000c);
        rdc(8'h0c, 16'h0008);
        conv(8'h40, 8'h40, 1'b0);
        u_lsirq_host_model.wr(8'h0c, 16'h0000);
        rdc(8'h0c, 16'h0004);
        conv(8'h40, 8'h40, 1'b0);
        u_lsirq_host_model.wr(8'h0c, 16'h0001);
        rdc(8'h0c, 16'h0000);
        // infrared is selected; visible sits low so a wrong source shows up
        for (int f = 0; f < 4; f++)
        begin
            fault_count = f[1:0];
            conv(8'h40, 8'h40, 1'b0);
            repeat ((1 << f) - 1) conv(8'h08, 8'hf8, 1'b0);
            conv(8'h40, 8'h40, 1'b0);
            repeat ((1 << f) - 1) conv(8'h08, 8'hf8, 1'b0);
            rdc(8'h0c, 16'h0004);
            conv(8'h08, 8'hf8, 1'b0);
            rdc(8'h0c, 16'h0006);
        end
        u_lsirq_host_model.wr(8'h0b, 16'h2000);
        repeat (8) conv(8'h08, 8'hf8, 1'b0);
        rdc(8'h0c, 16'h0005);
        u_lsirq_host_model.wr(8'h0b, 16'h2014);
        chk({15'h0, irq_oe}, 16'h0001);
        conv(8'h40, 8'h40, 1'b0);
        chk({15'h0, pin_lvl}, 16'h0000);
        rdc(8'h0c, 16'h0004);
        chk({15'h0, pin_lvl}, 16'h0001);
        pol = 1'b1;
        @(negedge clk_i);
        chk({15'h0, pin_lvl}, 16'h0000);
        conv(8'h40, 8'h40, 1'b0);
        chk({15'h0, pin_lvl}, 16'h0001);
        rdc(8'h0c, 16'h0004);
        fault_count = 2'h0;
        u_lsirq_host_model.wr(8'h0b, 16'h2010);
        conv(8'h40, 8'h40, 1'b0);
        chk({15'h0, pin_lvl}, 16'h0000);
        conv(8'h08, 8'h40, 1'b0);
        chk({15'h0, pin_lvl}, 16'h0001);
        rdc(8'h0c, 16'h0005);
        // every-two and every-four modes count from zero after the switch
        u_lsirq_host_model.wr(8'h0b, 16'h2018);
        conv(8'h40, 8'h40, 1'b0);
        chk({15'h0, pin_lvl}, 16'h0000);
        conv(8'h40, 8'h40, 1'b0);
        chk({15'h0, pin_lvl}, 16'h0001);
        rdc(8'h0c, 16'h0004);
        u_lsirq_host_model.wr(8'h0b, 16'h201c);
        repeat (3) conv(8'h40, 8'h40, 1'b0);
        chk({15'h0, pin_lvl}, 16'h0000);
        conv(8'h40, 8'h40, 1'b0);
        chk({15'h0, pin_lvl}, 16'h0001);
        // lowered high limit; infrared sits low so a wrong source shows as low flag
        th_hi = 8'h30;
        conv(8'h40, 8'h08, 1'b0);
        rdc(8'h0c, 16'h0006);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
